// ### dlirq_unit.v
// Purpose: standard and extended interrupt unit of an 8051-compatible core
// Assumes: cpu core drives sfr bus and vector acknowledge on MCLK
// Notes: standard flags (timers, uart) live in their peripherals; only gating lives here
//
// Overview of operation
// - two active-low external pins, each edge or level sensitive.
// - internal sources: converter, serial peripheral, radio 1, radio 2, wakeup timer.
// - global gate zero masks every interrupt.
// - global gate one passes each source by its own enable.
// - standard enable bits 5..0: timer2, uart, timer1, ext1, timer0, ext0.
// - timer 2 enable passes overflow or external flag.
// - uart enable passes transmit or receive flag.
// - enable bit 6 reads 0; level bit 7 reads 1, bit 6 reads 0.
// - standard level register mirrors enable positions; 1 means high priority.
// - radio 2 ready rising edge sets flag bit 7.
// - radio 1 ready rising edge sets flag bit 6.
// - software setting a flag raises the interrupt like hardware.
// - extended flag, enable and level registers at their own addresses.
// - extended enables bits 0..4; bits 7..5 read 1.
// - extended level mirrors extended enables; bits 7..5 read 1.
// - converter end rising edge sets flag bit 4.
// - wakeup flag in control bit 3, cleared by software.
`include "dlirq_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dlirq_unit (
    input wire MCLK,
    input wire RSTN,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    output reg [7:0] SFR_RDATA,
    output reg SFR_HIT,
    input wire EXT0_IRQ_PIN_N,
    input wire EXT1_IRQ_PIN_N,
    input wire EXT0_EDGE_MODE,
    input wire EXT1_EDGE_MODE,
    input wire TMR0_OVF_FLAG,
    input wire TMR1_OVF_FLAG,
    input wire TMR2_OVF_FLAG,
    input wire TMR2_EXT_FLAG,
    input wire UART_TX_FLAG,
    input wire UART_RX_FLAG,
    input wire ADC_IRQ_SRC,
    input wire SPI_IRQ_SRC,
    input wire RADIO1_PKT_RDY,
    input wire RADIO2_PKT_RDY,
    input wire WAKEUP_IRQ_SRC,
    input wire IRQ_ACK,
    input wire IRQ_RETI,
    output reg IRQ_REQ,
    output reg [3:0] IRQ_INDEX,
    output reg EXT0_EDGE_SEEN,
    output reg EXT1_EDGE_SEEN
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    reg [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // pins and cross-block event lines all come from outside this clock's view
    // peripheral flags may share this clock; two extra cycles of latency cost nothing
    localparam NSYNC = 15;
    wire [NSYNC-1:0] async_in = {WAKEUP_IRQ_SRC, RADIO2_PKT_RDY, RADIO1_PKT_RDY,
        SPI_IRQ_SRC, ADC_IRQ_SRC, UART_RX_FLAG, UART_TX_FLAG, TMR2_EXT_FLAG,
        TMR2_OVF_FLAG, TMR1_OVF_FLAG, TMR0_OVF_FLAG, ~EXT1_IRQ_PIN_N,
        ~EXT0_IRQ_PIN_N, EXT1_EDGE_MODE, EXT0_EDGE_MODE};
    reg [NSYNC-1:0] sync1_r;
    reg [NSYNC-1:0] sync2_r;
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= {NSYNC{1'b0}};
            sync2_r <= {NSYNC{1'b0}};
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end
    wire ext0_edge_mode = sync2_r[0];
    wire ext1_edge_mode = sync2_r[1];
    wire ext0_act = sync2_r[2];
    wire ext1_act = sync2_r[3];
    wire tmr0_ovf_flag = sync2_r[4];
    wire tmr1_ovf_flag = sync2_r[5];
    wire tmr2_ovf_flag = sync2_r[6];
    wire tmr2_ext_flag = sync2_r[7];
    wire uart_tx_flag = sync2_r[8];
    wire uart_rx_flag = sync2_r[9];
    wire [4:0] ext_evt_lvl = sync2_r[14:10];

    ////////////////////////////////////////////////////////////////////////////
    // edge detection: pins (falling edge, already inverted) and internal events
    // pins are inverted ahead of this, so one rising detector serves all seven lanes
    wire [6:0] rise;
    dlirq_edge #(.WIDTH(7)) u_edge (
        .clk(MCLK),
        .rst_n(rst_n),
        .level({ext_evt_lvl, ext1_act, ext0_act}),
        .rise(rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] std_irq_enable_r;
    reg [7:0] std_irq_level_r;
    reg [7:0] ext_irq_enable_r;
    reg [7:0] ext_irq_level_r;
    reg [4:0] ext_flag_r;
    reg [4:0] ext_flag_nxt;

    function sel;
        input [7:0] addr;
        input [7:0] target;
        begin
            sel = (addr == target);
        end
    endfunction

    wire wr_std_en = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_STD_EN);
    wire wr_std_lvl = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_STD_LVL);
    wire wr_ext_en = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_EXT_EN);
    wire wr_ext_lvl = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_EXT_LVL);
    wire wr_ext_flags = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_EXT_FLAGS);
    wire wr_ext_ctrl = SFR_WR && sel(SFR_ADDR, `DLIRQ_ADDR_EXT_CTRL);

    // flag order: adc, spi, radio1, radio2, wakeup
    // a write stores the value; a coinciding hardware edge still sets the flag
    always @* begin
        ext_flag_nxt = ext_flag_r;
        if (wr_ext_flags) begin
            ext_flag_nxt[0] = SFR_WDATA[`DLIRQ_FLG_ADC];
            ext_flag_nxt[1] = SFR_WDATA[`DLIRQ_FLG_SPI];
            ext_flag_nxt[2] = SFR_WDATA[`DLIRQ_FLG_RADIO1];
            ext_flag_nxt[3] = SFR_WDATA[`DLIRQ_FLG_RADIO2];
        end
        if (wr_ext_ctrl) begin
            ext_flag_nxt[4] = SFR_WDATA[`DLIRQ_FLG_WAKEUP];
        end
        ext_flag_nxt = ext_flag_nxt | rise[6:2];
    end

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            std_irq_enable_r <= `DLIRQ_RST_BYTE;
            std_irq_level_r <= `DLIRQ_RST_BYTE;
            ext_irq_enable_r <= `DLIRQ_RST_BYTE;
            ext_irq_level_r <= `DLIRQ_RST_BYTE;
            ext_flag_r <= 5'h0;
        end else begin
            if (wr_std_en) std_irq_enable_r <= SFR_WDATA & `DLIRQ_WM_STD_EN;
            if (wr_std_lvl) std_irq_level_r <= SFR_WDATA & `DLIRQ_WM_STD_LVL;
            if (wr_ext_en) ext_irq_enable_r <= SFR_WDATA & `DLIRQ_WM_EXT;
            if (wr_ext_lvl) ext_irq_level_r <= SFR_WDATA & `DLIRQ_WM_EXT;
            ext_flag_r <= ext_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external pins: edge mode latches until the core vectors, level mode follows pin
    // a level-mode pin never latches, so a mode switch cannot leave a stale edge behind
    wire [1:0] pin_act = {ext1_act, ext0_act};
    wire [1:0] pin_edge_mode = {ext1_edge_mode, ext0_edge_mode};
    wire [1:0] pin_latch;
    wire [1:0] pin_pend;
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pin
            wire [3:0] pin_index = (p == 0) ? `DLIRQ_IDX_EXT0 : `DLIRQ_IDX_EXT1;
            wire pin_ack = IRQ_ACK && (IRQ_INDEX == pin_index);
            reg latch_r;
            always @(posedge MCLK or negedge rst_n) begin
                if (!rst_n) begin
                    latch_r <= 1'b0;
                end else if (rise[p] && pin_edge_mode[p]) begin
                    latch_r <= 1'b1;
                end else if (pin_ack || !pin_edge_mode[p]) begin
                    latch_r <= 1'b0;
                end
            end
            assign pin_latch[p] = latch_r;
            // edge mode holds until vectored; a new edge in the ack cycle is kept
            assign pin_pend[p] = pin_edge_mode[p] ? latch_r : pin_act[p];
        end
    endgenerate
    wire ext0_pend = pin_pend[0];
    wire ext1_pend = pin_pend[1];

    ////////////////////////////////////////////////////////////////////////////
    // request gating, index order is natural priority
    wire gate = std_irq_enable_r[`DLIRQ_BIT_GATE];
    wire [`DLIRQ_NSRC-1:0] pend = {ext_flag_r[4], ext_flag_r[3], ext_flag_r[2],
        ext_flag_r[1], ext_flag_r[0], 1'b0,
        tmr2_ovf_flag | tmr2_ext_flag,
        uart_tx_flag | uart_rx_flag,
        tmr1_ovf_flag, ext1_pend, tmr0_ovf_flag};
    // enables and levels share one lane order: standard bits 5..0, a spare, extended 4..0
    function [`DLIRQ_NSRC:0] lanes;
        input [7:0] std_byte;
        input [7:0] ext_byte;
        begin
            lanes = {ext_byte[4:0], 1'b0, std_byte[5:0]};
        end
    endfunction
    // slot 0 is ext0; the shift below keeps index equal to natural order and to the standard enable bit
    wire [`DLIRQ_NSRC:0] pend_all = {pend, ext0_pend};
    wire [`DLIRQ_NSRC:0] en_all = lanes(std_irq_enable_r, ext_irq_enable_r);
    wire [`DLIRQ_NSRC:0] lvl_all = lanes(std_irq_level_r, ext_irq_level_r);
    wire [`DLIRQ_NSRC:0] armed = gate ? (pend_all & en_all) : {(`DLIRQ_NSRC+1){1'b0}};
    wire [`DLIRQ_NSRC:0] armed_hi = armed & lvl_all;

    // lowest set index wins within a level
    function [4:0] first_set;
        input [`DLIRQ_NSRC:0] v;
        integer i;
        begin
            first_set = {1'b0, `DLIRQ_IDX_NONE};
            for (i = `DLIRQ_NSRC; i >= 0; i = i - 1) begin
                if (v[i]) first_set = {1'b1, i[3:0]};
            end
        end
    endfunction
    wire [4:0] pick_hi = first_set(armed_hi);
    wire [4:0] pick_any = first_set(armed);

    ////////////////////////////////////////////////////////////////////////////
    // service tracking: two nesting levels, low then high
    // the core never acks and returns in one cycle; were it to, the ack is kept
    reg in_lo_r;
    reg in_hi_r;
    reg [4:0] pick;
    always @* begin
        pick = {1'b0, `DLIRQ_IDX_NONE};
        if (in_hi_r) pick = {1'b0, `DLIRQ_IDX_NONE};
        else if (in_lo_r) pick = pick_hi;
        else if (pick_hi[4]) pick = pick_hi;
        else pick = pick_any;
    end

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            in_lo_r <= 1'b0;
            in_hi_r <= 1'b0;
            IRQ_REQ <= 1'b0;
            IRQ_INDEX <= `DLIRQ_IDX_NONE;
        end else begin
            if (IRQ_ACK && IRQ_REQ) begin
                if (lvl_all[IRQ_INDEX]) in_hi_r <= 1'b1;
                else in_lo_r <= 1'b1;
            end else if (IRQ_RETI) begin
                if (in_hi_r) in_hi_r <= 1'b0;
                else in_lo_r <= 1'b0;
            end
            IRQ_REQ <= pick[4] && !(IRQ_ACK && IRQ_REQ);
            IRQ_INDEX <= pick[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    // reads have no side effects, so a polling loop cannot lose a flag
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            SFR_RDATA <= 8'h00;
            SFR_HIT <= 1'b0;
            EXT0_EDGE_SEEN <= 1'b0;
            EXT1_EDGE_SEEN <= 1'b0;
        end else begin
            EXT0_EDGE_SEEN <= pin_latch[0];
            EXT1_EDGE_SEEN <= pin_latch[1];
            SFR_HIT <= 1'b1;
            SFR_RDATA <= 8'h00;
            if (!SFR_RD) begin
                SFR_HIT <= 1'b0;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_STD_EN)) begin
                SFR_RDATA <= std_irq_enable_r | `DLIRQ_RO_STD_EN;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_STD_LVL)) begin
                SFR_RDATA <= std_irq_level_r | `DLIRQ_RO_STD_LVL;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_EXT_FLAGS)) begin
                SFR_RDATA <= {ext_flag_r[3], ext_flag_r[2], ext_flag_r[1],
                    ext_flag_r[0], 4'h0} | `DLIRQ_RO_EXT_FLAGS;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_EXT_CTRL)) begin
                SFR_RDATA <= {4'h0, ext_flag_r[4], 3'h0} | `DLIRQ_RO_EXT_CTRL;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_EXT_EN)) begin
                SFR_RDATA <= ext_irq_enable_r | `DLIRQ_RO_EXT_EN;
            end else if (sel(SFR_ADDR, `DLIRQ_ADDR_EXT_LVL)) begin
                SFR_RDATA <= ext_irq_level_r | `DLIRQ_RO_EXT_LVL;
            end else begin
                SFR_HIT <= 1'b0;
            end
        end
    end
endmodule // dlirq_unit
`default_nettype wire

// ### dlirq_map.vh
// Purpose: register offsets, field positions and reset values of the dual level interrupt unit
// Assumes: 8-bit special function register space of the cpu core
// Notes: included by the interrupt unit module only
`ifndef DLIRQ_MAP_VH
`define DLIRQ_MAP_VH

`define DLIRQ_ADDR_EXT_FLAGS 8'h91
`define DLIRQ_ADDR_STD_EN 8'hA8
`define DLIRQ_ADDR_STD_LVL 8'hB8
`define DLIRQ_ADDR_EXT_CTRL 8'hD8
`define DLIRQ_ADDR_EXT_EN 8'hE8
`define DLIRQ_ADDR_EXT_LVL 8'hF8

// standard enable / level positions
`define DLIRQ_BIT_GATE 7
`define DLIRQ_BIT_TMR2 5
`define DLIRQ_BIT_UART 4
`define DLIRQ_BIT_TMR1 3
`define DLIRQ_BIT_EXT1 2
`define DLIRQ_BIT_TMR0 1
`define DLIRQ_BIT_EXT0 0

// extended enable / level positions
`define DLIRQ_BIT_ADC 0
`define DLIRQ_BIT_SPI 1
`define DLIRQ_BIT_RADIO1 2
`define DLIRQ_BIT_RADIO2 3
`define DLIRQ_BIT_WAKEUP 4

// extended flag positions
`define DLIRQ_FLG_RADIO2 7
`define DLIRQ_FLG_RADIO1 6
`define DLIRQ_FLG_SPI 5
`define DLIRQ_FLG_ADC 4
`define DLIRQ_FLG_WAKEUP 3

// writable bits of the enable and level registers
`define DLIRQ_WM_STD_EN 8'hBF
`define DLIRQ_WM_STD_LVL 8'h3F
`define DLIRQ_WM_EXT 8'h1F

// request indices of the two pins, used to clear their edge latches
`define DLIRQ_IDX_EXT0 4'h0
`define DLIRQ_IDX_EXT1 4'h2

// reset values and fixed read bits
`define DLIRQ_RST_BYTE 8'h00
`define DLIRQ_RO_STD_EN 8'h00
`define DLIRQ_RO_STD_LVL 8'h80
`define DLIRQ_RO_EXT_FLAGS 8'h08
`define DLIRQ_RO_EXT_CTRL 8'h40
`define DLIRQ_RO_EXT_EN 8'hE0
`define DLIRQ_RO_EXT_LVL 8'hE0

// number of sources, index order is natural priority
`define DLIRQ_NSRC 11
`define DLIRQ_IDX_W 4
`define DLIRQ_IDX_NONE 4'hF

`endif

// ### dlirq_edge.v
// Purpose: rising edge detector for the pin and internal event lines of the interrupt unit
// Assumes: inputs already synchronised to MCLK
// Notes: one pulse per rising edge per lane
`timescale 1ns/100ps
`default_nettype none
module dlirq_edge #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] level,
    output reg [WIDTH-1:0] rise
);
    reg [WIDTH-1:0] prev_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= {WIDTH{1'b0}};
            rise <= {WIDTH{1'b0}};
        end else begin
            prev_r <= level;
            rise <= level & ~prev_r;
        end
    end
endmodule // dlirq_edge
`default_nettype wire

// ### dlirq_unit_props.sv
// Purpose: port-level checker for the dual level interrupt unit
// Assumes: single MCLK domain, raw RSTN as disable
// Notes: gate copy follows writes to the standard enable register
`timescale 1ns/100ps
`default_nettype none
module dlirq_props (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_HIT,
    input wire logic IRQ_ACK,
    input wire logic IRQ_REQ,
    input wire logic [3:0] IRQ_INDEX
);
    logic gate_r;
    logic mapped;
    assign mapped = SFR_ADDR inside {8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE8, 8'hF8};
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN)
            gate_r <= 1'b0;
        else if (SFR_WR && SFR_ADDR == 8'hA8)
            gate_r <= SFR_WDATA[7];
    end
    ////////////////////////////////////////
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    map_hit_a: assert property (SFR_RD && mapped |=> SFR_HIT)
        else $error("mapped read without hit");
    unmap_zero_a: assert property (SFR_RD && !mapped |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("unmapped read answered");
    en_rsv_a: assert property (SFR_RD && SFR_ADDR == 8'hA8 |=> !SFR_RDATA[6])
        else $error("enable bit 6 not zero");
    lvl_rsv_a: assert property (SFR_RD && SFR_ADDR == 8'hB8 |=> SFR_RDATA[7:6] == 2'b10)
        else $error("level top bits wrong");
    xen_rsv_a: assert property (SFR_RD && SFR_ADDR == 8'hE8 |=> SFR_RDATA[7:5] == 3'b111)
        else $error("ext enable top bits wrong");
    xlvl_rsv_a: assert property (SFR_RD && SFR_ADDR == 8'hF8 |=> SFR_RDATA[7:5] == 3'b111)
        else $error("ext level top bits wrong");
    gate_mask_a: assert property (!gate_r [*2] |=> !IRQ_REQ)
        else $error("request with gate closed");
    ack_drop_a: assert property ($rose(IRQ_ACK) |=> !IRQ_REQ)
        else $error("request held after ack");
    req_index_a: assert property (IRQ_REQ |-> IRQ_INDEX != 4'hF && IRQ_INDEX != 4'h6)
        else $error("request with no source");
endmodule // dlirq_props
bind dlirq_unit dlirq_props u_props (.MCLK(MCLK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .SFR_HIT(SFR_HIT), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_INDEX(IRQ_INDEX));
`default_nettype wire

// ### dlirq_core_model.sv
// Purpose: cpu core stand-in that vectors on request and returns on command
// Assumes: one ack per request, pulse of one cycle
// Notes: ack_wait selects a prompt or a slow answer
`timescale 1ns/100ps
`default_nettype none
module dlirq_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_req,
    input wire logic [3:0] ack_wait,
    input wire logic reti_go,
    output logic irq_ack,
    output logic irq_reti
);
    logic [3:0] cnt_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            irq_ack <= 1'b0;
            irq_reti <= 1'b0;
        end else begin
            irq_reti <= reti_go;
            irq_ack <= irq_req && !irq_ack && cnt_r == ack_wait;
            // a request that vanishes while waiting restarts the count
            cnt_r <= (irq_req && !irq_ack && cnt_r != ack_wait) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule // dlirq_core_model
`default_nettype wire

// ### dual_level_irq_unit_bench.sv
// Purpose: self-checking bench for the dual level interrupt unit
// Assumes: core model answers requests, software clears flags
// Notes: registers, gating, per-source enables, flags, preemption
`timescale 1ns/100ps
`default_nettype none
module dual_level_irq_unit_bench;
    logic MCLK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic reti_go = 1'b0;
    logic [3:0] ack_wait = 4'h0;
    logic [7:0] std_in = 8'h00;
    logic [4:0] ev = 5'h00;
    logic [1:0] edge_md = 2'b10;
    logic [7:0] rdata;
    logic [3:0] idx;
    logic hit, req, ack, reti;
    logic seen0, seen1;
    int n_errors = 0;
    int n_compared = 0;
    always #25 MCLK = ~MCLK;
    dlirq_unit dut (.MCLK(MCLK), .RSTN(RSTN), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_HIT(hit),
        .EXT0_IRQ_PIN_N(!std_in[0]), .EXT1_IRQ_PIN_N(!std_in[2]),
        .EXT0_EDGE_MODE(edge_md[0]), .EXT1_EDGE_MODE(edge_md[1]),
        .TMR0_OVF_FLAG(std_in[1]), .TMR1_OVF_FLAG(std_in[3]), .TMR2_OVF_FLAG(std_in[6]),
        .TMR2_EXT_FLAG(std_in[7]), .UART_TX_FLAG(std_in[4]), .UART_RX_FLAG(std_in[5]),
        .ADC_IRQ_SRC(ev[0]), .SPI_IRQ_SRC(ev[1]), .RADIO1_PKT_RDY(ev[2]),
        .RADIO2_PKT_RDY(ev[3]), .WAKEUP_IRQ_SRC(ev[4]), .IRQ_ACK(ack), .IRQ_RETI(reti),
        .IRQ_REQ(req), .IRQ_INDEX(idx), .EXT0_EDGE_SEEN(seen0), .EXT1_EDGE_SEEN(seen1));
    dlirq_core_model u_core (.clk(MCLK), .rst_n(RSTN), .irq_req(req), .ack_wait(ack_wait),
        .reti_go(reti_go), .irq_ack(ack), .irq_reti(reti));
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        tick(1);
        check(rdata, exp);
        check({7'h0, hit}, {7'h0, a != 8'h90});
        rd = 1'b0;
        tick(1);
    endtask
    task automatic wait_req(input logic [3:0] exp_idx);
        int i;
        i = 0;
        while (req !== 1'b1 && i < 30) begin
            tick(1);
            i++;
        end
        check({7'h0, req}, 8'h01);
        check({4'h0, idx}, {4'h0, exp_idx});
    endtask
    task automatic quiet(input int n);
        tick(n);
        check({7'h0, req}, 8'h00);
    endtask
    task automatic ret;
        reti_go = 1'b1;
        tick(1);
        reti_go = 1'b0;
        tick(1);
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] a [6] = '{8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE8, 8'hF8};
        logic [7:0] rv [6] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'hE0, 8'hE0};
        logic [7:0] wv [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
        logic [7:0] wx [6] = '{8'h08, 8'hBF, 8'hBF, 8'h40, 8'hFF, 8'hFF};
        for (int k = 0; k < 6; k++) rdchk(a[k], rv[k]);
        for (int k = 0; k < 6; k++) sfr_wr(a[k], wv[k]);
        for (int k = 0; k < 6; k++) rdchk(a[k], wx[k]);
        sfr_wr(8'h90, 8'hFF);
        rdchk(8'h90, 8'h00);
        for (int k = 0; k < 6; k++) sfr_wr(a[k], 8'h00);
    endtask
    // one pass per standard source; tx/rx and overflow/external share an enable
    task automatic t_std;
        int b;
        ack_wait = 4'h0;
        for (int k = 0; k < 8; k++) begin
            b = (k < 4) ? k : (k < 6 ? 4 : 5);
            sfr_wr(8'hA8, 8'hBF & ~(8'h01 << b));
            std_in[k] = 1'b1;
            quiet(10);
            check({6'h0, seen1, seen0}, (k == 2) ? 8'h02 : 8'h00);
            sfr_wr(8'hA8, 8'h80 | (8'h01 << b));
            wait_req(b[3:0]);
            tick(4);
            // the edge-mode pin stays low through the return: it must not fire again
            if (k != 2) std_in[k] = 1'b0;
            tick(6);
            ret;
            quiet(6);
            std_in[k] = 1'b0;
            check({6'h0, seen1, seen0}, 8'h00);
        end
    endtask
    // slow core answers; flag must outlive the ack until software clears it
    task automatic t_ext;
        logic [7:0] fa;
        logic [7:0] fz;
        ack_wait = 4'h5;
        sfr_wr(8'hA8, 8'h80);
        for (int j = 0; j < 5; j++) begin
            fa = (j < 4) ? 8'h91 : 8'hD8;
            fz = (j < 4) ? 8'h08 : 8'h40;
            sfr_wr(8'hE8, 8'h01 << j);
            ev[j] = 1'b1;
            wait_req(4'h7 + j[3:0]);
            tick(10);
            ev[j] = 1'b0;
            rdchk(fa, fz | ((j < 4) ? (8'h10 << j) : 8'h08));
            sfr_wr(fa, 8'h00);
            rdchk(fa, fz);
            ret;
            quiet(6);
        end
    endtask
    task automatic t_gate;
        ack_wait = 4'h0;
        sfr_wr(8'hA8, 8'h00);
        sfr_wr(8'hE8, 8'h1F);
        sfr_wr(8'h91, 8'h20);
        quiet(10);
        rdchk(8'h91, 8'h28);
        sfr_wr(8'hA8, 8'h80);
        wait_req(4'h8);
        quiet(8);
        sfr_wr(8'hF8, 8'h04);
        sfr_wr(8'h91, 8'h60);
        wait_req(4'h9);
        tick(4);
        sfr_wr(8'h91, 8'h00);
        ret;
        ret;
        quiet(6);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge MCLK);
        #1;
        RSTN = 1'b1;
        tick(4);
        t_regs;
        t_std;
        t_ext;
        t_gate;
        tally_and_finish;
    end
    // tests take well under a thousand cycles; this limit of 20000 cycles is far beyond that
    initial begin
        #(50 * 20000);
        n_errors++;
        tally_and_finish;
    end
endmodule // dual_level_irq_unit_bench
`default_nettype wire
